// ==== core/tws_slave.sv ====
`timescale 1ns/10ps

module tws_slave #(
   parameter bit HAS_ADDR_PIN = 1'b1,
   parameter int TMO_CYC      = tws_pkg::TMO_CYC_DEF,
   parameter int CNT_W        = 22
) (
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       ce_i,
   input  wire logic       link_clk_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       address_select_input_i,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic [7:0]      reg_addr_o,
   output logic [7:0]      reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   import tws_pkg::*;

   function automatic logic [6:0] own_addr(input logic       pin,
                                           input logic [1:0] sel);
      own_addr = pin ? {ADDR_FIXED_UPPER, sel}
                     : ADDR_FIXED_8BIT[7:1];
   endfunction

   // ==========================================================================
   // Link domain reset, enable and pin synchronisers
   logic lrst_m_r, lrst_r, lce_m_r, lce_r;
   logic scl_m_r, scl_s_r, scl_d_r;
   logic sda_m_r, sda_s_r, sda_d_r;
   logic asel_m_r, asel_s_r;
   logic rack_m_r, rack_s_r, rack_d_r;
   logic tmo_m_r, tmo_s_r, tmo_d_r;
   logic rd_ack_tgl_r, tmo_tgl_r;

   always_ff @(posedge link_clk_i) begin
      lrst_m_r <= sys_rst_i;
      lrst_r   <= lrst_m_r;
      lce_m_r  <= ce_i;
      lce_r    <= lce_m_r;
   end

   always_ff @(posedge link_clk_i) begin
      if (lrst_r) begin
         {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
         {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
         {asel_m_r, asel_s_r}        <= 2'h0;
         {rack_m_r, rack_s_r, rack_d_r} <= 3'h0;
         {tmo_m_r, tmo_s_r, tmo_d_r} <= 3'h0;
      end else if (lce_r) begin
         scl_m_r  <= scl_i;
         scl_s_r  <= scl_m_r;
         scl_d_r  <= scl_s_r;
         sda_m_r  <= sda_i;
         sda_s_r  <= sda_m_r;
         sda_d_r  <= sda_s_r;
         asel_m_r <= address_select_input_i;
         asel_s_r <= asel_m_r;
         rack_m_r <= rd_ack_tgl_r;
         rack_s_r <= rack_m_r;
         rack_d_r <= rack_s_r;
         tmo_m_r  <= tmo_tgl_r;
         tmo_s_r  <= tmo_m_r;
         tmo_d_r  <= tmo_s_r;
      end
   end

   logic scl_rise, scl_fall, start_ev, stop_ev, rack_ev, tmo_ev;
   assign scl_rise = scl_s_r & ~scl_d_r;
   assign scl_fall = ~scl_s_r & scl_d_r;
   assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
   assign stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
   assign rack_ev  = rack_s_r ^ rack_d_r;
   assign tmo_ev   = tmo_s_r ^ tmo_d_r;

   // ==========================================================================
   // Address select sensing
   logic       asel_idle_r, asel_start_r, asel_fall_r;
   logic [1:0] sel_code;
   tws_state_e state_r;
   tws_kind_e  kind_r;
   logic [3:0] bitcnt_r;

   always_ff @(posedge link_clk_i) begin
      if (lrst_r) begin
         asel_idle_r  <= 1'b0;
         asel_start_r <= 1'b0;
         asel_fall_r  <= 1'b0;
      end else if (lce_r) begin
         if (state_r == ST_IDLE && scl_s_r && sda_s_r && !start_ev)
            asel_idle_r <= asel_s_r;
         if (start_ev)
            asel_start_r <= asel_s_r;
         if (scl_fall && state_r == ST_RX && kind_r == K_ADDR &&
             bitcnt_r == BIT_ZERO)
            asel_fall_r <= asel_s_r;
      end
   end

   // Tie to GND reads low always, SDA low at START, SCL low at first fall
   always_comb begin
      if (!asel_idle_r)
         sel_code = SEL_GND;
      else if (!asel_start_r)
         sel_code = SEL_SDA;
      else if (!asel_fall_r)
         sel_code = SEL_SCL;
      else
         sel_code = SEL_VDD;
   end

   // ==========================================================================
   // Protocol engine
   logic [7:0] shift_r, ptr_r, rdata_lk_r;
   logic [7:0] wr_addr_r, wr_data_r, rd_addr_r, rdata_hold_r;
   logic       wr_tgl_r, rd_tgl_r, rw_r, mack_ok_r, act_r, bus_low_r;
   logic       sda_oe_r, sda_o_r;
   logic       addr_hit;

   assign addr_hit = shift_r[7:1] == own_addr(HAS_ADDR_PIN, sel_code);

   always_ff @(posedge link_clk_i) begin
      if (lrst_r)
         rdata_lk_r <= 8'h00;
      else if (lce_r && rack_ev)
         rdata_lk_r <= rdata_hold_r;
   end

   always_ff @(posedge link_clk_i) begin
      if (lrst_r) begin
         state_r   <= ST_IDLE;
         kind_r    <= K_ADDR;
         bitcnt_r  <= BIT_ZERO;
         shift_r   <= 8'h00;
         ptr_r     <= PTR_RST;
         rw_r      <= 1'b0;
         mack_ok_r <= 1'b0;
         act_r     <= 1'b0;
         sda_oe_r  <= 1'b0;
         wr_tgl_r  <= 1'b0;
         rd_tgl_r  <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
         rd_addr_r <= 8'h00;
      end else if (lce_r) begin
         if (tmo_ev) begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
            act_r    <= 1'b0;
         end else if (start_ev) begin
            state_r  <= ST_RX;
            kind_r   <= K_ADDR;
            bitcnt_r <= BIT_ZERO;
            sda_oe_r <= 1'b0;
            act_r    <= 1'b1;
         end else if (stop_ev) begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
            act_r    <= 1'b0;
         end else begin
            case (state_r)
               ST_RX: begin
                  if (scl_rise && bitcnt_r != RX_LAST) begin
                     shift_r  <= {shift_r[6:0], sda_s_r};
                     bitcnt_r <= bitcnt_r + BIT_ONE;
                  end else if (scl_fall && bitcnt_r == RX_LAST) begin
                     state_r  <= ST_ACK;
                     sda_oe_r <= 1'b1;
                     case (kind_r)
                        K_ADDR: begin
                           if (!addr_hit) begin
                              state_r  <= ST_IGN;
                              sda_oe_r <= 1'b0;
                           end else begin
                              rw_r <= shift_r[0];
                              if (shift_r[0]) begin
                                 rd_addr_r <= ptr_r;
                                 rd_tgl_r  <= ~rd_tgl_r;
                              end
                           end
                        end
                        K_CMD: ptr_r <= shift_r;
                        default: begin
                           wr_addr_r <= ptr_r;
                           wr_data_r <= shift_r;
                           wr_tgl_r  <= ~wr_tgl_r;
                           ptr_r     <= ptr_r + PTR_INC;
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bitcnt_r <= BIT_ZERO;
                     if (rw_r) begin
                        state_r   <= ST_TX;
                        shift_r   <= rdata_lk_r;
                        sda_oe_r  <= ~rdata_lk_r[7];
                        ptr_r     <= ptr_r + PTR_INC;
                        rd_addr_r <= ptr_r + PTR_INC;
                        rd_tgl_r  <= ~rd_tgl_r;
                     end else begin
                        state_r  <= ST_RX;
                        sda_oe_r <= 1'b0;
                        kind_r   <= (kind_r == K_ADDR) ? K_CMD : K_DATA;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bitcnt_r == TX_LAST) begin
                        state_r  <= ST_MACK;
                        sda_oe_r <= 1'b0;
                     end else begin
                        shift_r  <= {shift_r[6:0], 1'b0};
                        sda_oe_r <= ~shift_r[6];
                        bitcnt_r <= bitcnt_r + BIT_ONE;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise)
                     mack_ok_r <= ~sda_s_r;
                  else if (scl_fall) begin
                     bitcnt_r <= BIT_ZERO;
                     if (mack_ok_r) begin
                        state_r   <= ST_TX;
                        shift_r   <= rdata_lk_r;
                        sda_oe_r  <= ~rdata_lk_r[7];
                        ptr_r     <= ptr_r + PTR_INC;
                        rd_addr_r <= ptr_r + PTR_INC;
                        rd_tgl_r  <= ~rd_tgl_r;
                     end else
                        state_r <= ST_IGN;
                  end
               end
               ST_IDLE, ST_IGN: sda_oe_r <= 1'b0;
               default: begin
                  state_r  <= ST_IDLE;
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain data: only a low level is ever driven, clock never driven
   always_ff @(posedge link_clk_i) begin
      if (lrst_r) begin
         sda_o_r   <= 1'b0;
         bus_low_r <= 1'b0;
      end else if (lce_r) begin
         sda_o_r   <= 1'b0;
         bus_low_r <= act_r & ~tmo_ev & (~scl_s_r | ~sda_s_r);
      end
   end

   assign sda_o    = sda_o_r;
   assign sda_oe_o = sda_oe_r;

   // ==========================================================================
   // System domain: register port and timeout
   logic       wr_m_r, wr_s_r, wr_d_r, rd_m_r, rd_s_r, rd_d_r;
   logic       low_m_r, low_s_r;
   logic       reg_wr_r, reg_rd_r, rd_cap_r, tmo_dis_r;
   logic [7:0] reg_addr_r, reg_wdata_r;
   logic [CNT_W-1:0] tmo_cnt_r;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         {wr_m_r, wr_s_r, wr_d_r} <= 3'h0;
         {rd_m_r, rd_s_r, rd_d_r} <= 3'h0;
         {low_m_r, low_s_r}       <= 2'h0;
      end else if (ce_i) begin
         wr_m_r  <= wr_tgl_r;
         wr_s_r  <= wr_m_r;
         wr_d_r  <= wr_s_r;
         rd_m_r  <= rd_tgl_r;
         rd_s_r  <= rd_m_r;
         rd_d_r  <= rd_s_r;
         low_m_r <= bus_low_r;
         low_s_r <= low_m_r;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         reg_wr_r     <= 1'b0;
         reg_rd_r     <= 1'b0;
         rd_cap_r     <= 1'b0;
         reg_addr_r   <= 8'h00;
         reg_wdata_r  <= 8'h00;
         rdata_hold_r <= 8'h00;
         rd_ack_tgl_r <= 1'b0;
         tmo_dis_r    <= TMO_DIS_RST;
      end else if (ce_i) begin
         reg_wr_r <= wr_s_r ^ wr_d_r;
         reg_rd_r <= rd_s_r ^ rd_d_r;
         rd_cap_r <= reg_rd_r;
         if (wr_s_r ^ wr_d_r) begin
            reg_addr_r  <= wr_addr_r;
            reg_wdata_r <= wr_data_r;
         end else if (rd_s_r ^ rd_d_r)
            reg_addr_r <= rd_addr_r;
         if (rd_cap_r) begin
            rdata_hold_r <= reg_rdata_i;
            rd_ack_tgl_r <= ~rd_ack_tgl_r;
         end
         if (reg_wr_r && reg_addr_r == CFG_REG_OFS)
            tmo_dis_r <= reg_wdata_r[TMO_DIS_BIT];
      end
   end

   // Counted on the system clock, which stands for the internal oscillator
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tmo_cnt_r <= '0;
         tmo_tgl_r <= 1'b0;
      end else if (ce_i) begin
         if (!low_s_r || tmo_dis_r)
            tmo_cnt_r <= '0;
         else if (tmo_cnt_r == CNT_W'(TMO_CYC - 1)) begin
            tmo_cnt_r <= '0;
            tmo_tgl_r <= ~tmo_tgl_r;
         end else
            tmo_cnt_r <= tmo_cnt_r + 1'b1;
      end
   end

   assign reg_wr_o    = reg_wr_r;
   assign reg_rd_o    = reg_rd_r;
   assign reg_addr_o  = reg_addr_r;
   assign reg_wdata_o = reg_wdata_r;

   // ==========================================================================
   // Assertions
   a_sda_low_only: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r) sda_oe_o |-> !sda_o)
      else $error("data line driven high");
   a_start_begins: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r) start_ev && !tmo_ev
      |=> state_r == ST_RX && bitcnt_r == BIT_ZERO && !sda_oe_r)
      else $error("START not taken");
   a_stop_frees: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r) stop_ev |=> state_r == ST_IDLE
      && !sda_oe_r && !act_r)
      else $error("STOP did not free bus");
   a_oe_held_high: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r)
      scl_s_r && $past(scl_s_r) && !tmo_ev && !start_ev && !stop_ev
      |=> $stable(sda_oe_r))
      else $error("data changed while clock high");
   a_addr_ack: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r)
      state_r == ST_RX && scl_fall && bitcnt_r == RX_LAST && addr_hit
      && !start_ev && !stop_ev && !tmo_ev |=> sda_oe_r && state_r == ST_ACK)
      else $error("missing acknowledge");
   a_addr_miss: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r)
      state_r == ST_RX && kind_r == K_ADDR && scl_fall
      && bitcnt_r == RX_LAST && !addr_hit && !start_ev && !stop_ev
      && !tmo_ev |=> state_r == ST_IGN && !sda_oe_r)
      else $error("foreign address acknowledged");
   a_cmd_pointer: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r)
      state_r == ST_RX && kind_r == K_CMD && scl_fall
      && bitcnt_r == RX_LAST && !start_ev && !stop_ev && !tmo_ev
      |=> ptr_r == $past(shift_r) && $stable(wr_tgl_r))
      else $error("command byte not latched");
   a_write_advance: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r)
      state_r == ST_RX && kind_r == K_DATA && scl_fall
      && bitcnt_r == RX_LAST && !start_ev && !stop_ev && !tmo_ev
      |=> wr_tgl_r != $past(wr_tgl_r) && ptr_r == $past(ptr_r) + PTR_INC)
      else $error("write did not advance pointer");
   a_read_capture: assert property (@(posedge mclk_i)
      disable iff (sys_rst_i || !ce_i) reg_rd_o && ce_i
      |=> ##1 rdata_hold_r == $past(reg_rdata_i))
      else $error("read data not captured");
   a_tmo_fire: assert property (@(posedge mclk_i)
      disable iff (sys_rst_i || !ce_i)
      low_s_r && !tmo_dis_r && tmo_cnt_r == CNT_W'(TMO_CYC - 1)
      |=> tmo_tgl_r != $past(tmo_tgl_r))
      else $error("timeout missed");
   a_tmo_off: assert property (@(posedge mclk_i)
      disable iff (sys_rst_i || !ce_i) tmo_dis_r |=> tmo_cnt_r == '0)
      else $error("timeout ran while disabled");
   a_tmo_reset: assert property (@(posedge link_clk_i)
      disable iff (lrst_r || !lce_r) tmo_ev
      |=> state_r == ST_IDLE && !sda_oe_r)
      else $error("timeout did not reset interface");

   c_write: cover property (@(posedge mclk_i) reg_wr_o);
   c_read: cover property (@(posedge mclk_i) reg_rd_o);
   c_timeout: cover property (@(posedge link_clk_i) tmo_ev);
   c_miss: cover property (@(posedge link_clk_i) state_r == ST_IGN);

endmodule

// ==== core/tws_pkg.sv ====
// ==========================================================================
// Shared constants of the two-wire slave interface
package tws_pkg;

   // ==========================================================================
   // Addressing
   localparam logic [4:0] ADDR_FIXED_UPPER = 5'h13;   // 1,0,0,1,1
   localparam logic [7:0] ADDR_FIXED_8BIT  = 8'h98;   // no-pin variant
   localparam logic [1:0] SEL_GND          = 2'h0;
   localparam logic [1:0] SEL_VDD          = 2'h1;
   localparam logic [1:0] SEL_SDA          = 2'h2;
   localparam logic [1:0] SEL_SCL          = 2'h3;

   // ==========================================================================
   // Configuration snoop
   localparam logic [7:0] CFG_REG_OFS      = 8'h27;
   localparam int         TMO_DIS_BIT      = 7;
   localparam logic       TMO_DIS_RST      = 1'b0;

   // ==========================================================================
   // Bit counting and pointer
   localparam logic [3:0] BIT_ZERO         = 4'h0;
   localparam logic [3:0] BIT_ONE          = 4'h1;
   localparam logic [3:0] RX_LAST          = 4'h8;
   localparam logic [3:0] TX_LAST          = 4'h7;
   localparam logic [7:0] PTR_RST          = 8'h00;
   localparam logic [7:0] PTR_INC          = 8'h01;

   // ==========================================================================
   // Timing
   localparam int         CLK_HZ           = 100000000;
   localparam int         TMO_MS           = 31;
   localparam int         TMO_CYC_DEF      = (CLK_HZ / 1000) * TMO_MS;

   // ==========================================================================
   // Types
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RX   = 6'h02,
      ST_ACK  = 6'h04,
      ST_TX   = 6'h08,
      ST_MACK = 6'h10,
      ST_IGN  = 6'h20
   } tws_state_e;

   typedef enum logic [2:0] {
      K_ADDR = 3'h1,
      K_CMD  = 3'h2,
      K_DATA = 3'h4
   } tws_kind_e;

endpackage

// ==== dv/tws_master.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Bus master model: pushes the clock line, open-drain data line
module tws_master #(
   parameter int HALF = 20
) (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic half();
      repeat (HALF) @(posedge clk_i);
   endtask

   task automatic start_c();
      half();
      sda_o <= 1'b1;
      half();
      scl_o <= 1'b1;
      half();
      sda_o <= 1'b0;
      half();
      scl_o <= 1'b0;
   endtask

   task automatic stop_c();
      half();
      sda_o <= 1'b0;
      half();
      scl_o <= 1'b1;
      half();
      sda_o <= 1'b1;
   endtask

   // Data moves only while the clock is low; stall stretches the high phase
   task automatic bit_c(input logic b, input int stall, output logic r);
      half();
      sda_o <= b;
      half();
      scl_o <= 1'b1;
      half();
      repeat (stall) @(posedge clk_i);
      r = sda_i;
      scl_o <= 1'b0;
   endtask

   task automatic wr_byte(input logic [7:0] d, input int stall,
                          output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_c(d[i], 0, r);
      end
      bit_c(1'b1, stall, ack);
   endtask

   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, 0, r);
         d[i] = r;
      end
      bit_c(nack, 0, r);
   endtask
endmodule

// ==== dv/tws_slave_bench.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench of the two-wire slave
module tws_slave_bench import tws_pkg::*; ;
   typedef struct packed {
      logic [1:0] sel;
      logic [7:0] cmd;
      logic [7:0] d0;
      logic [7:0] d1;
   } tws_row_s;
   localparam int LIMIT = 80000;
   logic       mclk_i, link_clk_i, sys_rst_i, asel;
   logic [7:0] reg_rdata_i, reg_addr_o, reg_wdata_o, wr_cnt;
   logic       sda_o, sda_oe_o, reg_wr_o, reg_rd_o, scl_w, m_sda;
   logic [1:0] sel_mode;
   logic [7:0] mem [256];
   int         err_count, num_checks, cyc;
   wire        sda_w = sda_oe_o ? (sda_o & m_sda) : m_sda;
   tws_row_s   rows [4] = '{'{SEL_GND, 8'h10, 8'ha5, 8'h3c},
                            '{SEL_VDD, 8'hff, 8'h12, 8'h34},
                            '{SEL_SDA, 8'h40, 8'h00, 8'hff},
                            '{SEL_SCL, 8'h60, 8'h77, 8'h81}};

   assign asel = (sel_mode == SEL_GND) ? 1'b0 : (sel_mode == SEL_VDD) ?
                 1'b1 : (sel_mode == SEL_SDA) ? sda_w : scl_w;

   tws_slave #(.HAS_ADDR_PIN(1'b1), .TMO_CYC(2000), .CNT_W(22))
   tws_slave_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .link_clk_i(link_clk_i), .scl_i(scl_w), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .address_select_input_i(asel),
      .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o),
      .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i));

   tws_master #(.HALF(20)) tws_master_inst (.clk_i(mclk_i),
      .sda_i(sda_w), .scl_o(scl_w), .sda_o(m_sda));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #7;
      forever #24 link_clk_i = ~link_clk_i;
   end

   // ==========================================================================
   // Register file behind the register port
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   always @(posedge mclk_i) begin
      if (reg_wr_o === 1'b1) begin
         mem[reg_addr_o] <= reg_wdata_o;
         wr_cnt <= wr_cnt + 8'h01;
      end
      if (reg_rd_o === 1'b1) reg_rdata_i <= mem[reg_addr_o];
   end

   // ==========================================================================
   // Checks and verdict
   task automatic chk_byte(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      tws_master_inst.wr_byte(b, 0, a);
      chk_bit("ack", exp_ack, a);
   endtask

   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         print_verdict();
      end
   end

   // ==========================================================================
   // Main sequence
   initial begin
      logic [7:0] aw, rd, wc;
      logic       a;
      sys_rst_i = 1'b1;
      reg_rdata_i = 8'h00;
      wr_cnt = 8'h00;
      sel_mode = SEL_GND;
      err_count = 0;
      num_checks = 0;
      cyc = 0;
      repeat (20) @(posedge mclk_i);
      chk_bit("rst oe", 1'b0, sda_oe_o);
      chk_bit("rst wr", 1'b0, reg_wr_o);
      chk_byte("rst addr", 8'h00, reg_addr_o);
      sys_rst_i <= 1'b0;
      repeat (30) @(posedge mclk_i);
      for (int i = 0; i < 4; i++) begin
         sel_mode <= rows[i].sel;
         aw = {ADDR_FIXED_UPPER, rows[i].sel, 1'b0};
         tws_master_inst.start_c();
         send(aw, 1'b0);
         send(rows[i].cmd, 1'b0);
         send(rows[i].d0, 1'b0);
         send(rows[i].d1, 1'b0);
         tws_master_inst.stop_c();
         repeat (20) @(posedge mclk_i);
         chk_byte("wr0", rows[i].d0, mem[rows[i].cmd]);
         chk_byte("wr1", rows[i].d1, mem[rows[i].cmd + 8'h01]);
         tws_master_inst.start_c();
         send(aw, 1'b0);
         send(rows[i].cmd, 1'b0);
         tws_master_inst.start_c();
         send(aw | 8'h01, 1'b0);
         tws_master_inst.rd_byte(1'b0, rd);
         chk_byte("rd0", rows[i].d0, rd);
         tws_master_inst.rd_byte(1'b1, rd);
         chk_byte("rd1", rows[i].d1, rd);
         tws_master_inst.stop_c();
         tws_master_inst.start_c();
         send(aw ^ 8'h02, 1'b1);
         send(8'h00, 1'b1);
         tws_master_inst.stop_c();
      end
      sel_mode <= SEL_GND;
      aw = {ADDR_FIXED_UPPER, SEL_GND, 1'b0};
      wc = wr_cnt;
      tws_master_inst.start_c();
      send(aw, 1'b0);
      send(8'h50, 1'b0);
      tws_master_inst.stop_c();
      repeat (20) @(posedge mclk_i);
      chk_byte("wr count", wc, wr_cnt);
      tws_master_inst.start_c();
      send(aw | 8'h01, 1'b0);
      tws_master_inst.rd_byte(1'b0, rd);
      chk_byte("ptr rd0", 8'h50 ^ 8'h5a, rd);
      tws_master_inst.rd_byte(1'b1, rd);
      chk_byte("ptr rd1", 8'h51 ^ 8'h5a, rd);
      tws_master_inst.stop_c();
      tws_master_inst.start_c();
      tws_master_inst.wr_byte(aw, 3000, a);
      chk_bit("tmo ack", 1'b1, a);
      chk_bit("tmo oe", 1'b0, sda_oe_o);
      send(aw, 1'b1);
      tws_master_inst.stop_c();
      tws_master_inst.start_c();
      send(aw, 1'b0);
      send(CFG_REG_OFS, 1'b0);
      send(8'h80, 1'b0);
      tws_master_inst.stop_c();
      tws_master_inst.start_c();
      tws_master_inst.wr_byte(aw, 3000, a);
      chk_bit("no tmo ack", 1'b0, a);
      send(CFG_REG_OFS, 1'b0);
      send(8'h00, 1'b0);
      tws_master_inst.stop_c();
      repeat (20) @(posedge mclk_i);
      print_verdict();
   end
endmodule
